/* hw/uef_consts.svh */
// register indexes, field positions and reset values for the enhanced
// flow-control block; definitions only, included by the modules
`ifndef UEF_CONSTS_SVH
`define UEF_CONSTS_SVH
`define UEF_A_IER 5'h00
`define UEF_A_ISR 5'h01
`define UEF_A_FCR 5'h02
`define UEF_A_MCR 5'h03
`define UEF_A_MSR 5'h04
`define UEF_A_SPR 5'h05
`define UEF_A_DLL 5'h06
`define UEF_A_DLM 5'h07
`define UEF_A_DLD 5'h08
`define UEF_A_TCR 5'h09
`define UEF_A_TLR 5'h0A
`define UEF_A_EFR 5'h0B
`define UEF_A_FLOW_ON_CHAR_ONE 5'h0C
`define UEF_A_FLOW_ON_CHAR_TWO 5'h0D
`define UEF_A_FLOW_OFF_CHAR_ONE 5'h0E
`define UEF_A_FLOW_OFF_CHAR_TWO 5'h0F
`define UEF_A_IOCTL 5'h10
`define UEF_EFR_ENH 4
`define UEF_EFR_SPEC 5
`define UEF_EFR_ARTS 6
`define UEF_EFR_ACTS 7
`define UEF_IER_SPEC 5
`define UEF_ISR_SPEC 4
`define UEF_ISR_XOFF 5
`define UEF_MCR_RTS 1
`define UEF_IOCTL_SRST 3
`define UEF_MASK_IER 8'hF0
`define UEF_MASK_ISR 8'h30
`define UEF_MASK_FCR 8'h30
`define UEF_MASK_MCR 8'hE4
`define UEF_MASK_ALL 8'hFF
`define UEF_RST_ZERO 8'h00
`define UEF_RST_ISR 8'h01
`define UEF_RST_TCR 8'h0F
`define UEF_POR_DLL 8'h01
`define UEF_POR_DLM 8'h00
`define UEF_POR_SPR 8'hFF
`define UEF_POR_FLOW 8'h00
`define UEF_MODE_P1 2'b10
`define UEF_MODE_P2 2'b01
`define UEF_MODE_BOTH 2'b11
`endif

/* hw/uef_pkg.sv */
// types shared by the enhanced flow-control block
// assumes the constants header sits beside it
package uef_pkg;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } rx_char_t;
  typedef struct packed {
    logic push;
    logic [7:0] data;
    logic special;
    logic xoff;
    logic xon;
  } rx_evt_t;
  typedef enum logic {RTS_RUN, RTS_HALT} rts_state_t;
endpackage : uef_pkg

/* hw/rx_char_filter.sv */
// received-character compare against the flow and special characters
// assumes one character per i_rx.valid pulse, synchronous to the clock
`timescale 1ns/100ps
`include "uef_consts.svh"
module rx_char_filter import uef_pkg::*; (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire rx_char_t i_rx,
  input wire logic [7:0] i_efr,
  input wire logic [7:0] i_flow_on_char_one,
  input wire logic [7:0] i_flow_on_char_two,
  input wire logic [7:0] i_flow_off_char_one,
  input wire logic [7:0] i_flow_off_char_two,
  output rx_evt_t o_evt
);
  logic [1:0] mode;
  logic cmp1, cmp2, is_off, is_on, spec, push;
  always_comb begin
    mode = i_efr[1:0];
    cmp1 = (mode == `UEF_MODE_P1) || (mode == `UEF_MODE_BOTH);
    cmp2 = (mode == `UEF_MODE_P2) || (mode == `UEF_MODE_BOTH);
    is_off = (cmp1 && i_rx.data == i_flow_off_char_one) ||
             (cmp2 && i_rx.data == i_flow_off_char_two);
    is_on = (cmp1 && i_rx.data == i_flow_on_char_one) ||
            (cmp2 && i_rx.data == i_flow_on_char_two);
    // bitwise equality keeps bit 0 on the lsb of the character
    spec = i_efr[`UEF_EFR_SPEC] && (i_rx.data == i_flow_off_char_two);
    // a compared flow character never reaches the fifo, special or not
    push = !(is_off || is_on);
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || !i_rx.valid) begin
      o_evt <= '0;
    end else begin
      o_evt <= '{push: push, data: i_rx.data, special: spec,
                 xoff: is_off, xon: is_on};
    end
  end
endmodule : rx_char_filter

/* hw/rts_flow_ctrl.sv */
// automatic rts halt/resume against the receive fifo fill
// assumes i_fill is the live receive fifo count, 0 up to its depth
`timescale 1ns/100ps
`include "uef_consts.svh"
module rts_flow_ctrl import uef_pkg::*; #(
  parameter int FILL_W = 7
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [FILL_W-1:0] i_fill,
  input wire logic [FILL_W-1:0] i_halt_lvl,
  input wire logic [FILL_W-1:0] i_resume_lvl,
  input wire logic [FILL_W-1:0] i_trig_lvl,
  input wire logic i_auto_en,
  input wire logic i_rts_reg,
  output logic o_rts_n,
  output logic o_trig
);
  rts_state_t st_q, st_d;
  always_comb begin
    st_d = st_q;
    if (!(i_auto_en && i_rts_reg)) begin
      st_d = RTS_RUN;
    end else begin
      case (st_q)
        RTS_RUN: if (i_fill >= i_halt_lvl) st_d = RTS_HALT;
        RTS_HALT: if (i_fill < i_resume_lvl) st_d = RTS_RUN;
        default: st_d = RTS_RUN;
      endcase
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      st_q <= RTS_RUN;
    end else begin
      st_q <= st_d;
    end
  end
  // pin is high at reset, then follows the register unless halted
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_rts_n <= 1'b1;
    end else begin
      o_rts_n <= !i_rts_reg || (st_d == RTS_HALT);
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_trig <= 1'b0;
    end else begin
      o_trig <= i_auto_en && (i_fill >= i_trig_lvl);
    end
  end
endmodule : rts_flow_ctrl

/* hw/uart_enhanced_flow_control.sv */
// enhanced-feature register set and flow control for a uart
// assumes a synchronous register port and a receiver delivering characters
// Function
// - enhanced-enable gates writes to extended bits
// - reset clears extended bits except tcr (loads 0x0F), and fractional divisor
// - special detect matches second off character
// - compare bit zero against character lsb
// - pair one compare and detect independent
// - pair two: off two dropped, interrupts raised
// - auto rts halts at halt level
// - auto rts resumes below resume level
// - without auto, rts follows register
// - auto cts blocks new characters while high
// - four flow characters readable and writable
// - power-up divisor is one
// - power-up-only registers ignore other resets
// - reset clears change bits, shows inverted inputs
// - low enhanced bits select flow pairs
`timescale 1ns/100ps
`include "uef_consts.svh"
module uart_enhanced_flow_control import uef_pkg::*; #(
  parameter int FILL_W = 7
) (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_por_n,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [4:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire rx_char_t i_rx,
  input wire logic [FILL_W-1:0] i_rx_fill,
  input wire logic [3:0] i_modem_n,
  input wire logic i_tx_req,
  output logic [7:0] o_reg_rdata,
  output rx_evt_t o_rx_evt,
  output logic o_rts_n,
  output logic o_rx_trig_irq,
  output logic o_special_irq,
  output logic o_xoff_irq,
  output logic o_tx_start,
  output logic o_tx_halted
);
  logic [7:0] ier_q, isr_q, fcr_q, mcr_q, msr_q, spr_q;
  logic [7:0] dll_q, dlm_q, dld_q, tcr_q, tlr_q, efr_q;
  logic [7:0] flow_on_char_one_q, flow_on_char_two_q, flow_off_char_one_q, flow_off_char_two_q;
  logic [3:0] modem_prev_q;
  logic srst_q, rst, enh, sw_halt_q;
  logic [FILL_W-1:0] halt_lvl, resume_lvl, trig_lvl;
  rx_evt_t evt;

  // locked bits keep their stored value when enhanced writes are off
  function automatic logic [7:0] lock_merge(input logic [7:0] old_v,
      input logic [7:0] new_v, input logic [7:0] mask, input logic en);
    lock_merge = en ? new_v : ((new_v & ~mask) | (old_v & mask));
  endfunction : lock_merge

  function automatic logic hit(input logic [4:0] a, input logic [4:0] b);
    hit = (a == b);
  endfunction : hit

  // software reset acts like the pin reset; neither touches power-up registers
  always_comb begin
    rst = !i_rstn || srst_q;
    enh = efr_q[`UEF_EFR_ENH];
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      srst_q <= 1'b0;
    end else begin
      srst_q <= i_reg_wr && hit(i_reg_addr, `UEF_A_IOCTL) &&
                i_reg_wdata[`UEF_IOCTL_SRST];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (rst) begin
      efr_q <= `UEF_RST_ZERO;
    end else if (i_reg_wr && hit(i_reg_addr, `UEF_A_EFR)) begin
      efr_q <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (rst) begin
      ier_q <= `UEF_RST_ZERO;
    end else if (i_reg_wr && hit(i_reg_addr, `UEF_A_IER)) begin
      ier_q <= lock_merge(ier_q, i_reg_wdata, `UEF_MASK_IER, enh);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (rst) begin
      fcr_q <= `UEF_RST_ZERO;
    end else if (i_reg_wr && hit(i_reg_addr, `UEF_A_FCR)) begin
      fcr_q <= lock_merge(fcr_q, i_reg_wdata, `UEF_MASK_FCR, enh);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (rst) begin
      mcr_q <= `UEF_RST_ZERO;
    end else if (i_reg_wr && hit(i_reg_addr, `UEF_A_MCR)) begin
      mcr_q <= lock_merge(mcr_q, i_reg_wdata, `UEF_MASK_MCR, enh);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (rst) begin
      dld_q <= `UEF_RST_ZERO;
    end else if (i_reg_wr && enh && hit(i_reg_addr, `UEF_A_DLD)) begin
      dld_q <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (rst) begin
      tcr_q <= `UEF_RST_TCR;
    end else if (i_reg_wr && enh && hit(i_reg_addr, `UEF_A_TCR)) begin
      tcr_q <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (rst) begin
      tlr_q <= `UEF_RST_ZERO;
    end else if (i_reg_wr && enh && hit(i_reg_addr, `UEF_A_TLR)) begin
      tlr_q <= i_reg_wdata;
    end
  end

  // status bits: a hardware set in the same cycle as a clear wins
  always_ff @(posedge i_clk_sys) begin
    if (rst) begin
      isr_q <= `UEF_RST_ISR;
    end else begin
      if (i_reg_wr && hit(i_reg_addr, `UEF_A_ISR)) begin
        isr_q <= lock_merge(isr_q, i_reg_wdata, `UEF_MASK_ISR, enh);
      end else if (i_reg_rd && hit(i_reg_addr, `UEF_A_ISR)) begin
        isr_q[`UEF_ISR_SPEC] <= 1'b0;
        isr_q[`UEF_ISR_XOFF] <= 1'b0;
      end
      if (evt.special) begin
        isr_q[`UEF_ISR_SPEC] <= 1'b1;
      end
      if (evt.xoff) begin
        isr_q[`UEF_ISR_XOFF] <= 1'b1;
      end
    end
  end

  // power-up-only registers: pin and software reset leave them alone
  always_ff @(posedge i_clk_sys) begin
    if (!i_por_n) begin
      dll_q <= `UEF_POR_DLL;
    end else if (i_reg_wr && hit(i_reg_addr, `UEF_A_DLL)) begin
      dll_q <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_por_n) begin
      dlm_q <= `UEF_POR_DLM;
    end else if (i_reg_wr && hit(i_reg_addr, `UEF_A_DLM)) begin
      dlm_q <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_por_n) begin
      spr_q <= `UEF_POR_SPR;
    end else if (i_reg_wr && hit(i_reg_addr, `UEF_A_SPR)) begin
      spr_q <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_por_n) begin
      flow_on_char_one_q <= `UEF_POR_FLOW;
    end else if (i_reg_wr && hit(i_reg_addr, `UEF_A_FLOW_ON_CHAR_ONE)) begin
      flow_on_char_one_q <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_por_n) begin
      flow_on_char_two_q <= `UEF_POR_FLOW;
    end else if (i_reg_wr && hit(i_reg_addr, `UEF_A_FLOW_ON_CHAR_TWO)) begin
      flow_on_char_two_q <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_por_n) begin
      flow_off_char_one_q <= `UEF_POR_FLOW;
    end else if (i_reg_wr && hit(i_reg_addr, `UEF_A_FLOW_OFF_CHAR_ONE)) begin
      flow_off_char_one_q <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_por_n) begin
      flow_off_char_two_q <= `UEF_POR_FLOW;
    end else if (i_reg_wr && hit(i_reg_addr, `UEF_A_FLOW_OFF_CHAR_TWO)) begin
      flow_off_char_two_q <= i_reg_wdata;
    end
  end

  // upper half always mirrors the inverted inputs, even in reset
  always_ff @(posedge i_clk_sys) begin
    modem_prev_q <= i_modem_n;
    msr_q[7:4] <= ~i_modem_n;
    if (rst) begin
      msr_q[3:0] <= 4'h0;
    end else begin
      if (i_reg_rd && hit(i_reg_addr, `UEF_A_MSR)) begin
        msr_q[3:0] <= 4'h0;
      end
      for (int i = 0; i < 4; i++) begin
        if (i_modem_n[i] != modem_prev_q[i]) begin
          msr_q[i] <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (rst) begin
      o_reg_rdata <= `UEF_RST_ZERO;
    end else if (i_reg_rd) begin
      if (hit(i_reg_addr, `UEF_A_IER)) begin
        o_reg_rdata <= ier_q;
      end else if (hit(i_reg_addr, `UEF_A_ISR)) begin
        o_reg_rdata <= isr_q;
      end else if (hit(i_reg_addr, `UEF_A_FCR)) begin
        o_reg_rdata <= fcr_q;
      end else if (hit(i_reg_addr, `UEF_A_MCR)) begin
        o_reg_rdata <= mcr_q;
      end else if (hit(i_reg_addr, `UEF_A_MSR)) begin
        o_reg_rdata <= msr_q;
      end else if (hit(i_reg_addr, `UEF_A_SPR)) begin
        o_reg_rdata <= spr_q;
      end else if (hit(i_reg_addr, `UEF_A_DLL)) begin
        o_reg_rdata <= dll_q;
      end else if (hit(i_reg_addr, `UEF_A_DLM)) begin
        o_reg_rdata <= dlm_q;
      end else if (hit(i_reg_addr, `UEF_A_DLD)) begin
        o_reg_rdata <= dld_q;
      end else if (hit(i_reg_addr, `UEF_A_TCR)) begin
        o_reg_rdata <= tcr_q;
      end else if (hit(i_reg_addr, `UEF_A_TLR)) begin
        o_reg_rdata <= tlr_q;
      end else if (hit(i_reg_addr, `UEF_A_EFR)) begin
        o_reg_rdata <= efr_q;
      end else if (hit(i_reg_addr, `UEF_A_FLOW_ON_CHAR_ONE)) begin
        o_reg_rdata <= flow_on_char_one_q;
      end else if (hit(i_reg_addr, `UEF_A_FLOW_ON_CHAR_TWO)) begin
        o_reg_rdata <= flow_on_char_two_q;
      end else if (hit(i_reg_addr, `UEF_A_FLOW_OFF_CHAR_ONE)) begin
        o_reg_rdata <= flow_off_char_one_q;
      end else if (hit(i_reg_addr, `UEF_A_FLOW_OFF_CHAR_TWO)) begin
        o_reg_rdata <= flow_off_char_two_q;
      end else begin
        // unmapped indexes read as zero
        o_reg_rdata <= `UEF_RST_ZERO;
      end
    end
  end

  rx_char_filter u_filter (
    .i_clk_sys(i_clk_sys),
    .i_rst(rst),
    .i_rx(i_rx),
    .i_efr(efr_q),
    .i_flow_on_char_one(flow_on_char_one_q),
    .i_flow_on_char_two(flow_on_char_two_q),
    .i_flow_off_char_one(flow_off_char_one_q),
    .i_flow_off_char_two(flow_off_char_two_q),
    .o_evt(evt)
  );

  // one more stage so the fifo push leaves straight from a flop here
  always_ff @(posedge i_clk_sys) begin
    if (rst) begin
      o_rx_evt <= '0;
    end else begin
      o_rx_evt <= evt;
    end
  end

  // levels are in steps of four characters, up to sixty
  always_comb begin
    halt_lvl = FILL_W'({tcr_q[3:0], 2'b00});
    resume_lvl = FILL_W'({tcr_q[7:4], 2'b00});
    trig_lvl = FILL_W'({tlr_q[7:4], 2'b00});
  end

  rts_flow_ctrl #(.FILL_W(FILL_W)) u_rts (
    .i_clk_sys(i_clk_sys),
    .i_rst(rst),
    .i_fill(i_rx_fill),
    .i_halt_lvl(halt_lvl),
    .i_resume_lvl(resume_lvl),
    .i_trig_lvl(trig_lvl),
    .i_auto_en(efr_q[`UEF_EFR_ARTS]),
    .i_rts_reg(mcr_q[`UEF_MCR_RTS]),
    .o_rts_n(o_rts_n),
    .o_trig(o_rx_trig_irq)
  );

  always_ff @(posedge i_clk_sys) begin
    if (rst) begin
      o_special_irq <= 1'b0;
      o_xoff_irq <= 1'b0;
    end else begin
      o_special_irq <= isr_q[`UEF_ISR_SPEC] && ier_q[`UEF_IER_SPEC];
      o_xoff_irq <= isr_q[`UEF_ISR_XOFF] && ier_q[`UEF_IER_SPEC];
    end
  end

  // received off halts our transmitter until an on arrives
  always_ff @(posedge i_clk_sys) begin
    if (rst || efr_q[1:0] == 2'b00) begin
      sw_halt_q <= 1'b0;
    end else if (evt.xoff) begin
      sw_halt_q <= 1'b1;
    end else if (evt.xon) begin
      sw_halt_q <= 1'b0;
    end
  end

  // a character already started is not cut; only new starts are held
  always_ff @(posedge i_clk_sys) begin
    if (rst) begin
      o_tx_halted <= 1'b0;
      o_tx_start <= 1'b0;
    end else begin
      o_tx_halted <= sw_halt_q ||
                     (efr_q[`UEF_EFR_ACTS] && i_modem_n[0]);
      o_tx_start <= i_tx_req && !sw_halt_q &&
                    !(efr_q[`UEF_EFR_ACTS] && i_modem_n[0]);
    end
  end
endmodule : uart_enhanced_flow_control

/* verif/uef_sva.sv */
// port checker for the enhanced flow-control block
// assumes a bind from the bench top; mirrors efr and mcr bit1 from writes
`timescale 1ns/100ps
`include "uef_consts.svh"
module uef_sva import uef_pkg::*; #(
  parameter int FILL_W = 7
) (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [4:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire rx_char_t i_rx,
  input wire logic [3:0] i_modem_n,
  input wire logic i_tx_req,
  input wire logic [7:0] o_reg_rdata,
  input wire rx_evt_t o_rx_evt,
  input wire logic o_rts_n,
  input wire logic o_rx_trig_irq,
  input wire logic o_special_irq,
  input wire logic o_tx_start
);
  logic [7:0] efr_q;
  logic mcr1_q;
  logic [1:0] sw_cnt_q;
  wire wr_sw = i_reg_wr && i_reg_addr == `UEF_A_IOCTL && i_reg_wdata[3];
  wire evt_any = o_rx_evt.push | o_rx_evt.special | o_rx_evt.xoff |
    o_rx_evt.xon;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  // software reset lands a cycle late, so mirror checks rest meanwhile
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) sw_cnt_q <= 2'h0;
    else if (wr_sw) sw_cnt_q <= 2'h3;
    else if (sw_cnt_q != 2'h0) sw_cnt_q <= sw_cnt_q - 2'h1;
  end
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn || wr_sw) efr_q <= 8'h00;
    else if (i_reg_wr && i_reg_addr == `UEF_A_EFR) efr_q <= i_reg_wdata;
  end
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn || wr_sw) mcr1_q <= 1'b0;
    else if (i_reg_wr && i_reg_addr == `UEF_A_MCR) mcr1_q <= i_reg_wdata[1];
  end
  a_evt_has_cause: assert property (
    evt_any |-> $past(i_rx.valid, 2)) else $error("event without char");
  a_evt_data_match: assert property (
    o_rx_evt.push |-> o_rx_evt.data == $past(i_rx.data, 2))
    else $error("pushed data differs");
  a_flow_no_push: assert property (
    (o_rx_evt.xoff || o_rx_evt.xon) |-> !o_rx_evt.push)
    else $error("flow char pushed");
  a_special_irq_cause: assert property (
    $rose(o_special_irq) |-> $past(o_rx_evt.special) || $past(i_reg_wr) ||
    $past(i_reg_wr, 2)) else $error("special irq without cause");
  a_start_needs_req: assert property (
    o_tx_start |-> $past(i_tx_req)) else $error("start without request");
  a_cts_blocks_start: assert property (
    $past(efr_q[7]) && $past(i_modem_n[0]) |-> !o_tx_start)
    else $error("start while cts high");
  a_rts_follows_reg: assert property (
    sw_cnt_q == 2'h0 && $past(!efr_q[6]) |-> o_rts_n == !$past(mcr1_q))
    else $error("rts not following register");
  a_trig_needs_auto: assert property (
    sw_cnt_q == 2'h0 && o_rx_trig_irq |-> $past(efr_q[6]))
    else $error("trigger irq without auto rts");
  a_rdata_holds: assert property (
    sw_cnt_q == 2'h0 && $past(i_rstn) && !$past(i_reg_rd) &&
    !$past(i_reg_rd, 2) |-> $stable(o_reg_rdata))
    else $error("read data moved without read");
  c_special: cover property (o_rx_evt.special && o_rx_evt.xoff);
  c_rts_halt: cover property (efr_q[6] && o_rts_n);
  c_cts_hold: cover property (efr_q[7] && i_tx_req && !o_tx_start);
endmodule : uef_sva

/* verif/uart_peer_model.sv */
// remote serial peer: hands received chars over and drives the modem pins
// assumes the bench calls its tasks; changes pins on the falling edge
`timescale 1ns/100ps
module uart_peer_model import uef_pkg::*; (
  input wire logic i_clk_sys,
  output rx_char_t o_rx,
  output logic [3:0] o_modem_n
);
  initial begin
    o_rx = '0;
    o_modem_n = 4'hA;
  end
  task automatic send_char(input logic [7:0] d);
    @(negedge i_clk_sys);
    o_rx = '{valid: 1'b1, data: d};
    @(negedge i_clk_sys);
    // stale data inverted so a match never rides on a leftover value
    o_rx = '{valid: 1'b0, data: ~d};
  endtask : send_char
  task automatic set_cts_n(input logic lvl);
    @(negedge i_clk_sys);
    o_modem_n[0] = lvl;
  endtask : set_cts_n
endmodule : uart_peer_model

/* verif/uart_enhanced_flow_control_tb_top.sv */
// self-checking bench for the enhanced flow-control block
// assumes the peer drives rx and modem pins; checker bound at the foot
`timescale 1ns/100ps
module uart_enhanced_flow_control_tb_top import uef_pkg::*; ();
  localparam logic [4:0] RA [17] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04,
    5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E,
    5'h0F, 5'h1F};
  localparam logic [7:0] RV [17] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h50,
    8'hFF, 8'h01, 8'h00, 8'h00, 8'h0F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00};
  localparam logic [7:0] MODES [5] = '{8'h10, 8'h12, 8'h32, 8'h31, 8'h33};
  localparam logic [6:0] CORNER [7] = '{7'h0F, 7'h10, 7'h09, 7'h08, 7'h07,
    7'h0C, 7'h0B};
  logic i_clk_sys, rstn, por_n, wr, rd, tx_req, rts_n, trig, rts_m, hlt;
  logic spec_irq, xoff_irq, tx_start, tx_halted;
  logic [4:0] addr;
  logic [7:0] wdata, rdata, d, efr_m, scratch_reg, dll;
  logic [7:0] fc [4];
  logic [6:0] fill;
  logic [3:0] modem_n, e;
  rx_char_t rx;
  rx_evt_t evt, acc;
  int n_mismatch, checked;
  uart_peer_model uart_peer_model_i (.i_clk_sys(i_clk_sys), .o_rx(rx),
    .o_modem_n(modem_n));
  uart_enhanced_flow_control #(.FILL_W(7)) uart_enhanced_flow_control_i (
    .i_clk_sys(i_clk_sys), .i_rstn(rstn), .i_por_n(por_n), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata), .i_rx(rx),
    .i_rx_fill(fill), .i_modem_n(modem_n), .i_tx_req(tx_req),
    .o_reg_rdata(rdata), .o_rx_evt(evt), .o_rts_n(rts_n),
    .o_rx_trig_irq(trig), .o_special_irq(spec_irq), .o_xoff_irq(xoff_irq),
    .o_tx_start(tx_start), .o_tx_halted(tx_halted));
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict
  task automatic check(input logic [18:0] seen, input logic [18:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wreg(input logic [4:0] a, input logic [7:0] v);
    @(negedge i_clk_sys);
    wr = 1'b1;
    addr = a;
    wdata = v;
    @(negedge i_clk_sys);
    wr = 1'b0;
  endtask : wreg
  task automatic rreg(input logic [4:0] a, output logic [7:0] v);
    @(negedge i_clk_sys);
    rd = 1'b1;
    addr = a;
    @(negedge i_clk_sys);
    rd = 1'b0;
    @(negedge i_clk_sys);
    v = rdata;
  endtask : rreg
  task automatic rchk(input logic [4:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rreg(a, v);
    check(19'(v), 19'(exp));
  endtask : rchk
  task automatic sefr(input logic [7:0] v);
    wreg(5'h0B, v);
    efr_m = v;
  endtask : sefr
  task automatic pchk();
    rchk(5'h05, scratch_reg);
    rchk(5'h06, dll);
    for (int i = 0; i < 4; i++) rchk(5'(12 + i), fc[i]);
  endtask : pchk
  // {push, special, xoff, xon} for a received char under the mirrored efr
  function automatic logic [3:0] flags(input logic [7:0] c);
    logic sp, xf, xn;
    sp = efr_m[5] && c == fc[3];
    xf = (efr_m[1] && c == fc[2]) || (efr_m[0] && c == fc[3]);
    xn = (efr_m[1] && c == fc[0]) || (efr_m[0] && c == fc[1]);
    return {!(xf || xn), sp, xf, xn};
  endfunction : flags
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    n_mismatch++;
    print_verdict();
  end
  initial begin
    {wr, rd, tx_req, rstn, por_n} = 5'h00;
    {addr, wdata, fill, efr_m} = '0;
    n_mismatch = 0;
    checked = 0;
    d = 8'($urandom(32'h25de_8201));
    repeat (16) @(negedge i_clk_sys);
    rstn = 1'b1;
    por_n = 1'b1;
    foreach (RA[i]) rchk(RA[i], RV[i]);
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      fc[i] = {6'($urandom), 2'(i)};
      wreg(5'(12 + i), fc[i]);
    end
    scratch_reg = 8'($urandom);
    dll = 8'($urandom);
    wreg(5'h05, scratch_reg);
    wreg(5'h06, dll);
    pchk();
    rstn = 1'b0;
    repeat (2) @(negedge i_clk_sys);
    rstn = 1'b1;
    pchk();
    sefr(8'h10);
    wreg(5'h10, 8'h08);
    repeat (3) @(negedge i_clk_sys);
    rchk(5'h0B, 8'h00);
    pchk();
    $display("test power-up registers done");
    wreg(5'h00, 8'hFF);
    rchk(5'h00, 8'h0F);
    wreg(5'h09, 8'h37);
    rchk(5'h09, 8'h0F);
    sefr(8'h10);
    wreg(5'h00, 8'hFF);
    rchk(5'h00, 8'hFF);
    sefr(8'h00);
    wreg(5'h00, 8'h00);
    rchk(5'h00, 8'hF0);
    wreg(5'h03, 8'hFF);
    rchk(5'h03, 8'h1B);
    check(19'(rts_n), 19'h0);
    wreg(5'h03, 8'h00);
    @(negedge i_clk_sys);
    check(19'(rts_n), 19'h1);
    $display("test write lock done");
    sefr(8'h90);
    tx_req = 1'b1;
    uart_peer_model_i.set_cts_n(1'b1);
    @(negedge i_clk_sys);
    check(19'({tx_start, tx_halted}), 19'h1);
    uart_peer_model_i.set_cts_n(1'b0);
    @(negedge i_clk_sys);
    check(19'({tx_start, tx_halted}), 19'h2);
    tx_req = 1'b0;
    $display("test auto cts done");
    sefr(8'h50);
    wreg(5'h09, 8'h24);
    wreg(5'h0A, 8'h30);
    wreg(5'h03, 8'h02);
    rts_m = 1'b0;
    for (int i = 0; i < 48; i++) begin
      fill = (i < 7) ? CORNER[i] : 7'($urandom_range(64));
      @(negedge i_clk_sys);
      if (fill >= 7'h10) rts_m = 1'b1;
      else if (fill < 7'h08) rts_m = 1'b0;
      check(19'(rts_n), 19'(rts_m));
      check(19'(trig), 19'(fill >= 7'h0C));
    end
    fill = 7'h00;
    $display("test auto rts done");
    sefr(8'h10);
    wreg(5'h00, 8'h20);
    foreach (MODES[m]) begin
      sefr(8'h10);
      hlt = 1'b0;
      sefr(MODES[m]);
      for (int k = 0; k < 6; k++) begin
        d = (k == 0) ? fc[3] : (k == 1) ? fc[3] ^ 8'h01 :
          (k == 5) ? 8'($urandom) : fc[k - 2];
        e = flags(d);
        uart_peer_model_i.send_char(d);
        acc = '0;
        repeat (3) begin
          @(negedge i_clk_sys);
          if (evt.push | evt.special | evt.xoff | evt.xon) acc = evt;
        end
        check(19'({acc.push, e[3] ? acc.data : 8'h00, acc[2:0]}),
          19'({e[3], e[3] ? d : 8'h00, e[2:0]}));
        check(19'({spec_irq, xoff_irq}), 19'(e[2:1]));
        if (e[1]) hlt = 1'b1;
        else if (e[0]) hlt = 1'b0;
        check(19'(tx_halted), 19'(hlt));
        rreg(5'h01, d);
      end
    end
    $display("test char detect done");
    print_verdict();
  end
endmodule : uart_enhanced_flow_control_tb_top
bind uart_enhanced_flow_control uef_sva #(.FILL_W(FILL_W)) uef_sva_i (
  .i_clk_sys, .i_rstn, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata,
  .i_rx, .i_modem_n, .i_tx_req, .o_reg_rdata, .o_rx_evt, .o_rts_n,
  .o_rx_trig_irq, .o_special_irq, .o_tx_start);
